// >>> rtl/dspad_map.vh
// constants for the arithmetic datapath
`ifndef DSPAD_MAP_VH
`define DSPAD_MAP_VH
`define DSPAD_OP_NOP   4'h0
`define DSPAD_OP_ADD   4'h1
`define DSPAD_OP_SUB   4'h2
`define DSPAD_OP_LOAD  4'h3
`define DSPAD_OP_AND   4'h4
`define DSPAD_OP_OR    4'h5
`define DSPAD_OP_XOR   4'h6
`define DSPAD_OP_ADDP  4'h7
`define DSPAD_OP_SUBP  4'h8
`define DSPAD_OP_LOADP 4'h9
`define DSPAD_OP_LOADT 4'ha
`define DSPAD_OP_MUL   4'hb
`define DSPAD_OP_MULI  4'hc
`define DSPAD_OP_STHI  4'hd
`define DSPAD_OP_STLO  4'he
`define DSPAD_OP_ZERO  4'hf
`define DSPAD_ST_X1    2'h1
`define DSPAD_ST_X4    2'h2
`define DSPAD_SHIFT_MAX 5'h10
`define DSPAD_WD_RST   16'h0000
`define DSPAD_WE_RST   1'b0
`define DSPAD_FLAG_RST 1'b0
`define DSPAD_SRC_RAM  1'b0
`define DSPAD_SRC_IMM  1'b1
`define DSPAD_ACC_RST  32'h00000000
`define DSPAD_P_RST    32'h00000000
`define DSPAD_T_RST    16'h0000
`define DSPAD_MAX_POS  32'h7fffffff
`define DSPAD_MAX_NEG  32'h80000000
`define DSPAD_IMM_W    13
`endif

// >>> rtl/dspad_mult.v
// signed 16 x 16 multiplier array, combinational
`timescale 1ns/1ps
module dspad_mult #(
	parameter W = 16
) (
	input  wire signed [W-1:0]   A,
	input  wire signed [W-1:0]   B,
	output wire signed [2*W-1:0] P
);
	assign P = A * B;
endmodule

// >>> rtl/dspad_core.v
// central arithmetic datapath: alu, accumulator, multiplier, shifters
// How it works
// - 32-bit two's-complement alu on 16-bit ram or immediate operands
// - alu also does and, or, xor on its operands
// - accumulator captures alu results and feeds back as operand
// - accumulator is 32 bits, high word 31:16, low word 15:0
// - separate store ops write high or low accumulator word
// - signed 16x16 product, full 32 bits, in one cycle
// - t register holds multiplicand, p register holds product
// - second multiply operand from ram or immediate instruction field
// - ram words to add, sub and load pass a 0 to 16 place left shifter
// - shifter sign-extends above and zero-fills below
// - high-word store shifts accumulator left 0, 1 or 4; upper bits written
// - saturate select bit chooses saturation or wraparound
// - excess flag set on any alu overflow
`timescale 1ns/1ps
`include "dspad_map.vh"
module dspad_core #(
	parameter W = 16
) (
	input  wire                  CLK_SYS,
	input  wire                  RESETN,
	input  wire                  OP_VALID,
	input  wire [3:0]            OP_CODE,
	input  wire                  OP_SRC,
	input  wire [W-1:0]          RAM_RDATA,
	input  wire [`DSPAD_IMM_W-1:0] IMM,
	input  wire [4:0]            LOAD_SHIFT,
	input  wire [1:0]            STORE_SHIFT,
	input  wire                  SATURATE_SELECT_BIT,
	input  wire                  FLAG_CLEAR,
	output reg  [W-1:0]          RAM_WDATA,
	output reg                   RAM_WE,
	output wire [2*W-1:0]        ACC,
	output wire [2*W-1:0]        PROD,
	output wire [W-1:0]          TREG,
	output wire                  ARITH_EXCESS_FLAG
);
	reg        rst_s1_ff;
	reg        rst_s2_ff;
	reg [31:0] acc_ff;
	reg [31:0] nxt_acc;
	reg [31:0] p_ff;
	reg [31:0] nxt_p;
	reg [15:0] t_ff;
	reg [15:0] nxt_t;
	reg        flag_ff;
	reg        nxt_flag;
	reg [15:0] nxt_wdata;
	reg        nxt_we;
	reg [15:0] wdata_ff;
	reg        we_ff;
	reg [15:0] operand;
	reg [31:0] shifted;
	reg [32:0] sum;
	wire [31:0] product;
	wire        rst_n;

	always @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	assign rst_n = rst_s2_ff;

	// sign extend a 16-bit word to 32 bits
	function [31:0] sext16;
		input [15:0] v;
		begin
			sext16 = {{16{v[15]}}, v};
		end
	endfunction

	// signed add/sub with overflow detect; bit 32 carries overflow
	function [32:0] addov;
		input [31:0] a;
		input [31:0] b;
		input        sub;
		reg   [31:0] bb;
		reg   [31:0] r;
		begin
			bb = sub ? ~b : b;
			r = a + bb + {31'h0, sub};
			addov = {(a[31] == bb[31]) && (r[31] != a[31]), r};
		end
	endfunction

	// shift amount; codes above sixteen clamp rather than wrap
	function [4:0] shamt;
		input [4:0] s;
		begin
			if (s > `DSPAD_SHIFT_MAX)
				shamt = `DSPAD_SHIFT_MAX;
			else
				shamt = s;
		end
	endfunction

	// sign extend the immediate field to a data word
	function [15:0] imm_ext;
		input [`DSPAD_IMM_W-1:0] v;
		begin
			imm_ext = {{(16-`DSPAD_IMM_W){v[`DSPAD_IMM_W-1]}}, v};
		end
	endfunction

	// ops that pass the adder and so may overflow
	function is_arith;
		input [3:0] op;
		begin
			case (op)
			`DSPAD_OP_ADD,
			`DSPAD_OP_SUB,
			`DSPAD_OP_ADDP,
			`DSPAD_OP_SUBP:
				is_arith = 1'b1;
			default:
				is_arith = 1'b0;
			endcase
		end
	endfunction

	// upper accumulator word after the store shift; code 3 is no shift
	function [15:0] store_hi;
		input [31:0] a;
		input [1:0]  k;
		reg   [31:0] s;
		begin
			case (k)
			`DSPAD_ST_X1: s = a << 1;
			`DSPAD_ST_X4: s = a << 4;
			default:      s = a;
			endcase
			store_hi = s[31:16];
		end
	endfunction

	// clip to the limit on the side where the true result lies
	function [31:0] clip;
		input [32:0] s;
		input        sat;
		begin
			if (s[32] && sat)
				clip = s[31] ? `DSPAD_MAX_POS : `DSPAD_MAX_NEG;
			else
				clip = s[31:0];
		end
	endfunction

	dspad_mult #(
		.W (W)
	) u_mult (
		.A (t_ff),
		.B (operand),
		.P (product)
	);

	// operand select, shared by alu and multiplier; load shifter feeds add, sub and load only
	always @* begin
		if (OP_SRC == `DSPAD_SRC_IMM)
			operand = imm_ext(IMM);
		else
			operand = RAM_RDATA;
		shifted = sext16(operand) << shamt(LOAD_SHIFT);
	end

	// next state; an op is taken at the edge where it is valid
	always @* begin
		nxt_acc = acc_ff;
		nxt_p = p_ff;
		nxt_t = t_ff;
		nxt_flag = flag_ff;
		nxt_we = 1'b0;
		nxt_wdata = wdata_ff;
		sum = 33'h0;
		if (FLAG_CLEAR)
			nxt_flag = 1'b0;
		if (OP_VALID) begin
			case (OP_CODE)
			`DSPAD_OP_ADD:
				sum = addov(acc_ff, shifted, 1'b0);
			`DSPAD_OP_SUB:
				sum = addov(acc_ff, shifted, 1'b1);
			`DSPAD_OP_ADDP:
				sum = addov(acc_ff, p_ff, 1'b0);
			`DSPAD_OP_SUBP:
				sum = addov(acc_ff, p_ff, 1'b1);
			`DSPAD_OP_LOAD:
				nxt_acc = shifted;
			`DSPAD_OP_LOADP:
				nxt_acc = p_ff;
			`DSPAD_OP_ZERO:
				nxt_acc = `DSPAD_ACC_RST;
			// and clears the high word, or and xor keep it
			`DSPAD_OP_AND:
				nxt_acc = {16'h0000, acc_ff[15:0] & operand};
			`DSPAD_OP_OR:
				nxt_acc = {acc_ff[31:16], acc_ff[15:0] | operand};
			`DSPAD_OP_XOR:
				nxt_acc = {acc_ff[31:16], acc_ff[15:0] ^ operand};
			`DSPAD_OP_LOADT:
				nxt_t = operand;
			`DSPAD_OP_MUL, `DSPAD_OP_MULI:
				nxt_p = product;
			`DSPAD_OP_STHI: begin
				nxt_wdata = store_hi(acc_ff, STORE_SHIFT);
				nxt_we = 1'b1;
			end
			`DSPAD_OP_STLO: begin
				nxt_wdata = acc_ff[15:0];
				nxt_we = 1'b1;
			end
			default:
				nxt_acc = acc_ff;
			endcase
			if (is_arith(OP_CODE)) begin
				nxt_acc = clip(sum, SATURATE_SELECT_BIT);
				// set wins over a same-cycle clear
				if (sum[32])
					nxt_flag = 1'b1;
			end
		end
	end

	// state registers reset only on the synchronised copy
	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff <= `DSPAD_ACC_RST;
		end else begin
			acc_ff <= nxt_acc;
		end
	end

	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			p_ff <= `DSPAD_P_RST;
		end else begin
			p_ff <= nxt_p;
		end
	end

	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			t_ff <= `DSPAD_T_RST;
		end else begin
			t_ff <= nxt_t;
		end
	end

	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= `DSPAD_FLAG_RST;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			wdata_ff <= `DSPAD_WD_RST;
		end else begin
			wdata_ff <= nxt_wdata;
		end
	end

	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			we_ff <= `DSPAD_WE_RST;
		end else begin
			we_ff <= nxt_we;
		end
	end

	// store port straight from flops; write strobe lasts one cycle
	always @* begin
		RAM_WDATA = wdata_ff;
		RAM_WE = we_ff;
	end

	assign ACC = acc_ff;
	assign PROD = p_ff;
	assign TREG = t_ff;
	assign ARITH_EXCESS_FLAG = flag_ff;
endmodule

// >>> test/dspad_chk_asserts.sv
// port assertions for the arithmetic datapath
`timescale 1ns/1ps
module dspad_chk (
	input wire        CLK_SYS,
	input wire        RESETN,
	input wire        OP_VALID,
	input wire [3:0]  OP_CODE,
	input wire        OP_SRC,
	input wire [15:0] RAM_RDATA,
	input wire        FLAG_CLEAR,
	input wire [15:0] RAM_WDATA,
	input wire        RAM_WE,
	input wire [31:0] ACC,
	input wire [31:0] PROD,
	input wire [15:0] TREG,
	input wire        ARITH_EXCESS_FLAG
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	a_store_low: assert property (OP_VALID && OP_CODE == 4'he
		|=> RAM_WE && RAM_WDATA == $past(ACC[15:0])) else $error("stl");
	a_no_stray_we: assert property (!OP_VALID |=> !RAM_WE)
		else $error("we");
	a_mult_full: assert property (OP_VALID && OP_CODE == 4'hb
		&& !OP_SRC |=> $signed(PROD) ==
		$signed($past(TREG)) * $signed($past(RAM_RDATA))) else $error("mpy");
	a_t_load: assert property (OP_VALID && OP_CODE == 4'ha
		&& !OP_SRC |=> TREG == $past(RAM_RDATA)) else $error("ldt");
	a_p_to_acc: assert property (OP_VALID && OP_CODE == 4'h9
		|=> ACC == $past(PROD)) else $error("pac");
	a_acc_hold: assert property (!OP_VALID |=> $stable(ACC))
		else $error("acc");
	a_pt_hold: assert property (!OP_VALID |=> $stable({PROD, TREG}))
		else $error("pt");
	a_flag_sticky: assert property (ARITH_EXCESS_FLAG && !FLAG_CLEAR
		|=> ARITH_EXCESS_FLAG) else $error("flag");
endmodule
bind dspad_core dspad_chk chk (.*);

// >>> test/dsp_arith_datapath_tb.sv
// self-checking bench for the arithmetic datapath
`timescale 1ns/1ps
module dsp_arith_datapath_tb;
	reg         CLK_SYS = '0, RESETN = '0, OP_VALID = '0, OP_SRC = '0;
	reg         SATURATE_SELECT_BIT = '0, FLAG_CLEAR = '0;
	reg  [3:0]  OP_CODE = '0;
	reg  [15:0] RAM_RDATA = '0;
	reg  [12:0] IMM = '0;
	reg  [4:0]  LOAD_SHIFT = '0;
	reg  [1:0]  STORE_SHIFT = '0;
	wire [15:0] RAM_WDATA, TREG;
	wire [31:0] ACC, PROD;
	wire        RAM_WE, ARITH_EXCESS_FLAG;
	integer     bad_count = 0, comparisons = 0;
	always #5 CLK_SYS = ~CLK_SYS;
	dspad_core uut (.*);
	task chk(input [32:0] g, input [32:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("Error %0t: saw %h want %h", $time, g, e);
		end
	endtask
	// flag rides above acc so every op checks both
	task t(input [4:0] c, input [15:0] d, input [32:0] e,
		input [4:0] h = 5'h0);
		@(posedge CLK_SYS);
		{OP_VALID,OP_SRC,OP_CODE,RAM_RDATA,IMM} <= {1'h1,c,d,d[12:0]};
		{LOAD_SHIFT,STORE_SHIFT} <= {h,h[1:0]};
		@(posedge CLK_SYS);
		OP_VALID <= 1'h0;
		#1 chk({ARITH_EXCESS_FLAG, ACC}, e);
	endtask
	task shifts;
		t(5'h03, 16'h8001, 33'h80010000, 5'h10);
		t(5'h03, 16'h8001, 33'hfff80010, 5'h4);
		t(5'h0d, 16'h0, 33'hfff80010, 5'h1);
		chk({RAM_WE, RAM_WDATA}, 33'h1fff0);
		t(5'h0d, 16'h0, 33'hfff80010, 5'h2);
		chk(RAM_WDATA, 33'hff80);
		t(5'h0e, 16'h0, 33'hfff80010);
		chk({RAM_WE, RAM_WDATA}, 33'h10010);
	endtask
	task logic_ops;
		t(5'h04, 16'h0ff0, 33'h10);
		t(5'h05, 16'h0f00, 33'hf10);
		t(5'h06, 16'h00ff, 33'hfef);
	endtask
	task mult;
		t(5'h0a, 16'h8000, 33'hfef);
		chk(TREG, 33'h8000);
		t(5'h0b, 16'h8000, 33'hfef);
		chk(PROD, 33'h40000000);
		t(5'h09, 16'h0, 33'h40000000);
		t(5'h07, 16'h0, 33'h180000000);
		@(posedge CLK_SYS);
		{FLAG_CLEAR, SATURATE_SELECT_BIT} <= 2'h3;
		@(posedge CLK_SYS);
		FLAG_CLEAR <= 1'h0;
		t(5'h09, 16'h0, 33'h40000000);
		t(5'h07, 16'h0, 33'h17fffffff);
		t(5'h1c, 16'h1fff, 33'h17fffffff);
		chk(PROD, 33'h8000);
		t(5'h08, 16'h0, 33'h17fff7fff);
		t(5'h11, 16'h1, 33'h17fff8000);
	endtask
	// sub, clamp, store code 3, zero, set-over-clear, wrap, mid-run reset
	task extra;
		t(5'h02, 16'h0001, 33'h17fff7fff);
		t(5'h03, 16'h0001, 33'h100010000, 5'h1f);
		t(5'h0d, 16'h0, 33'h100010000, 5'h3);
		chk({RAM_WE, RAM_WDATA}, 33'h10001);
		@(posedge CLK_SYS);
		#1 chk(RAM_WE, 33'h0);
		t(5'h0f, 16'h0, 33'h100000000);
		t(5'h03, 16'h7fff, 33'h17fff0000, 5'h10);
		@(posedge CLK_SYS);
		FLAG_CLEAR <= 1'h1;
		t(5'h02, 16'h8000, 33'h17fffffff, 5'h10);
		{FLAG_CLEAR, SATURATE_SELECT_BIT} <= 2'h0;
		t(5'h02, 16'h8000, 33'h1ffffffff, 5'h10);
		@(posedge CLK_SYS);
		RESETN <= 1'h0;
		@(posedge CLK_SYS);
		#1 chk({ARITH_EXCESS_FLAG, ACC}, 33'h0);
		chk(PROD, 33'h0);
		RESETN <= 1'h1;
		repeat (3) @(posedge CLK_SYS);
		t(5'h03, 16'h1234, 33'h1234);
	endtask
	task end_of_test;
		$display("%0d checks, %0d errors", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge CLK_SYS);
		RESETN <= 1'h1;
		repeat (3) @(posedge CLK_SYS);
		shifts;
		logic_ops;
		mult;
		extra;
		end_of_test;
	end
endmodule
